// >>> rtl/audio_ctrl_pkg.sv
// constants for the audio control two-wire slave receiver
package audio_ctrl_pkg;
	// chip address: upper six bits fixed, bit 1 follows the strap, bit 0 is the write direction
	localparam logic [5:0] ADDR_HI        = 6'h0c;
	localparam logic       ADDR_DIR_WRITE = 1'h0;
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	// leading bits of a data byte
	localparam int         FUNC_MSB       = 7;
	localparam logic [1:0] FUNC_MUTELOUD  = 2'h0;
	localparam logic [1:0] FUNC_INPUT     = 2'h1;
	localparam logic [1:0] FUNC_CHANNEL   = 2'h2;
	// field positions inside the mute/loudness byte
	localparam int         SMUTE_FAST_BIT = 0;
	localparam int         SMUTE_OFF_BIT  = 2;
	localparam int         LOUD_OFF_BIT   = 3;
	localparam int         LOUD_20DB_BIT  = 4;
	// volume field: bits 6:5 both set means mute
	localparam logic [1:0] VOL_MUTE_CODE  = 2'h3;
	// channel select codes (1x means both)
	localparam logic [1:0] CHAN_RIGHT     = 2'h0;
	localparam logic [1:0] CHAN_LEFT      = 2'h1;
	// reset values
	localparam logic [6:0] VOL_RESET      = 7'h7e;
	localparam logic [1:0] CHAN_RESET     = 2'h2;
	localparam logic [1:0] INPUT_RESET    = 2'h0;
	localparam logic       SMUTE_ON_RESET = 1'h0;
	localparam logic       SMUTE_FAST_RST = 1'h0;
	localparam logic       LOUD_ON_RESET  = 1'h0;
	localparam logic       LOUD_20_RESET  = 1'h0;
	// receiver states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_ACK,
		ST_IGNORE
	} rx_state_type;
endpackage : audio_ctrl_pkg

// >>> rtl/pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter logic RESET_LEVEL = 1'h1
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// pin and filtered level
	input  wire logic pin,
	output var  logic level_r
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_nxt;

	// the filtered level moves only once stages two and three agree
	always_comb begin
		level_nxt = level_r;
		if (s2_r == s3_r) begin
			level_nxt = s3_r;
		end
	end

	// stage one feeds stage two and nothing else
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r    <= RESET_LEVEL;
			s2_r    <= RESET_LEVEL;
			s3_r    <= RESET_LEVEL;
			level_r <= RESET_LEVEL;
		end else begin
			s1_r    <= pin;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			level_r <= level_nxt;
		end
	end
endmodule : pin_sync
`default_nettype wire

// >>> rtl/audio_ctrl_i2c_slave_rx.sv
// write-only two-wire slave receiver and function decoder of the audio control processor
//
// Overview of operation
// [R01] data changes only while clock low
// [R02] data falls, clock high: start
// [R03] data rises, clock high: stop
// [R04] eight bits per byte, msb first
// [R05] ninth clock pulse carries acknowledge
// [R06] master releases data during acknowledge
// [R07] addressed device pulls data low on ack
// [R08] missing acknowledge lets master stop
// [R09] master may skip checking the acknowledge
// [R10] start, address, data bytes, stop
// [R11] address direction bit must be zero
// [R12] address bit one follows strap pin
// [R13] master clocks at most 100 kbit/s
// [R14] leading bits select the function
// [R15] volume: 1 dB, 8 dB steps, mute
// [R16] soft mute and loudness controls
// [R17] input select: mute or three sources
// [R18] channel select steers later volume bytes
// [R19] ignore transfer on address mismatch
// [R20] acknowledge but ignore prefix 111
`timescale 1ns/1ps
`default_nettype none
module audio_ctrl_i2c_slave_rx (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// two-wire bus pins
	input  wire logic       scl,
	input  wire logic       sda_i,
	output var  logic       sda_o_r,
	output var  logic       sda_oe_r,
	// address strap, high when the pin is left open
	input  wire logic       addr_open,
	// volume settings per channel
	output var  logic [6:0] left_vol_r,
	output var  logic       left_mute_r,
	output var  logic [6:0] right_vol_r,
	output var  logic       right_mute_r,
	// mute, loudness, input and channel settings
	output var  logic       soft_mute_on_r,
	output var  logic       soft_mute_fast_r,
	output var  logic       loud_on_r,
	output var  logic       loud_20db_r,
	output var  logic [1:0] input_sel_r,
	output var  logic [1:0] chan_sel_r,
	// bus status
	output var  logic       addressed_r
);
	logic                       scl_f;
	logic                       sda_f;
	logic                       strap_f;
	logic                       scl_prev_r;
	logic                       sda_prev_r;
	logic                       scl_rise;
	logic                       scl_fall;
	logic                       start_det;
	logic                       stop_det;
	audio_ctrl_pkg::rx_state_type state_r;
	audio_ctrl_pkg::rx_state_type state_nxt;
	logic [7:0]                 shift_r;
	logic [7:0]                 shift_nxt;
	logic [3:0]                 cnt_r;
	logic [3:0]                 cnt_nxt;
	logic                       sda_oe_nxt;
	logic                       addressed_nxt;
	logic                       byte_done;
	logic                       addr_match;
	logic                       apply;
	logic [6:0]                 left_vol_nxt;
	logic [6:0]                 right_vol_nxt;
	logic                       left_mute_nxt;
	logic                       right_mute_nxt;
	logic                       soft_mute_on_nxt;
	logic                       soft_mute_fast_nxt;
	logic                       loud_on_nxt;
	logic                       loud_20db_nxt;
	logic [1:0]                 input_sel_nxt;
	logic [1:0]                 chan_sel_nxt;

	// both bus lines and the strap come from outside the clock domain
	pin_sync #(.RESET_LEVEL(1'h1)) u_scl_sync (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pin     (scl),
		.level_r (scl_f)
	);
	pin_sync #(.RESET_LEVEL(1'h1)) u_sda_sync (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pin     (sda_i),
		.level_r (sda_f)
	);
	pin_sync #(.RESET_LEVEL(1'h1)) u_strap_sync (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.pin     (addr_open),
		.level_r (strap_f)
	);

	// edge and condition detection on the filtered levels
	assign scl_rise  = scl_f && !scl_prev_r;
	assign scl_fall  = !scl_f && scl_prev_r;
	// data moving while clock stays high is a start or stop, never data
	assign start_det = scl_f && scl_prev_r && sda_prev_r && !sda_f; // [R02] [R01]
	assign stop_det  = scl_f && scl_prev_r && !sda_prev_r && sda_f; // [R03] [R01]
	assign byte_done = (cnt_r == audio_ctrl_pkg::BITS_PER_BYTE);
	// strap open gives 0011001, grounded gives 0011000, direction must be write
	assign addr_match = (shift_r == {audio_ctrl_pkg::ADDR_HI, strap_f,
		audio_ctrl_pkg::ADDR_DIR_WRITE}); // [R12] [R11]
	assign apply = scl_fall && byte_done && (state_r == audio_ctrl_pkg::ST_DATA);

	// receive state machine
	always_comb begin
		state_nxt     = state_r;
		shift_nxt     = shift_r;
		cnt_nxt       = cnt_r;
		sda_oe_nxt    = sda_oe_r;
		addressed_nxt = addressed_r;
		if (stop_det) begin
			state_nxt     = audio_ctrl_pkg::ST_IDLE; // [R03] [R10]
			sda_oe_nxt    = 1'h0;
			addressed_nxt = 1'h0;
		end else if (start_det) begin
			// a repeated start also lands here and restarts the address phase
			state_nxt     = audio_ctrl_pkg::ST_ADDR; // [R02] [R10]
			cnt_nxt       = 4'h0;
			sda_oe_nxt    = 1'h0;
			addressed_nxt = 1'h0;
		end else begin
			case (state_r)
				audio_ctrl_pkg::ST_ADDR, audio_ctrl_pkg::ST_DATA: begin
					if (scl_rise && !byte_done) begin
						shift_nxt = {shift_r[6:0], sda_f}; // [R04]
						cnt_nxt   = cnt_r + 4'h1;
					end else if (scl_fall && byte_done) begin
						if (state_r == audio_ctrl_pkg::ST_DATA || addr_match) begin
							// drive low from this falling edge through the ninth pulse
							state_nxt     = audio_ctrl_pkg::ST_ACK; // [R05]
							sda_oe_nxt    = 1'h1; // [R07]
							addressed_nxt = 1'h1;
						end else begin
							state_nxt = audio_ctrl_pkg::ST_IGNORE; // [R19]
						end
					end
				end
				audio_ctrl_pkg::ST_ACK: begin
					// release only after the ninth pulse falls, whether or not it was sampled
					if (scl_fall) begin
						state_nxt  = audio_ctrl_pkg::ST_DATA; // [R09] [R08]
						sda_oe_nxt = 1'h0;
						cnt_nxt    = 4'h0;
					end
				end
				audio_ctrl_pkg::ST_IGNORE: begin
					sda_oe_nxt = 1'h0; // [R19]
				end
				default: begin
					state_nxt  = audio_ctrl_pkg::ST_IDLE;
					sda_oe_nxt = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= audio_ctrl_pkg::ST_IDLE;
			shift_r     <= 8'h00;
			cnt_r       <= 4'h0;
			sda_oe_r    <= 1'h0;
			sda_o_r     <= 1'h0;
			addressed_r <= 1'h0;
			scl_prev_r  <= 1'h1;
			sda_prev_r  <= 1'h1;
		end else begin
			state_r     <= state_nxt;
			shift_r     <= shift_nxt;
			cnt_r       <= cnt_nxt;
			sda_oe_r    <= sda_oe_nxt;
			sda_o_r     <= 1'h0; // only ever pulls low
			addressed_r <= addressed_nxt;
			scl_prev_r  <= scl_f;
			sda_prev_r  <= sda_f;
		end
	end

	// function decode, applied when the data byte is acknowledged
	always_comb begin
		left_vol_nxt       = left_vol_r;
		right_vol_nxt      = right_vol_r;
		soft_mute_on_nxt   = soft_mute_on_r;
		soft_mute_fast_nxt = soft_mute_fast_r;
		loud_on_nxt        = loud_on_r;
		loud_20db_nxt      = loud_20db_r;
		input_sel_nxt      = input_sel_r;
		chan_sel_nxt       = chan_sel_r;
		if (apply) begin
			if (!shift_r[audio_ctrl_pkg::FUNC_MSB]) begin
				// volume lands on the channel chosen by the last channel byte
				if (chan_sel_r != audio_ctrl_pkg::CHAN_RIGHT) begin
					left_vol_nxt = shift_r[6:0]; // [R14] [R18] [R15]
				end
				if (chan_sel_r != audio_ctrl_pkg::CHAN_LEFT) begin
					right_vol_nxt = shift_r[6:0]; // [R14] [R18] [R15]
				end
			end else begin
				case (shift_r[6:5])
					audio_ctrl_pkg::FUNC_MUTELOUD: begin
						soft_mute_on_nxt   = !shift_r[audio_ctrl_pkg::SMUTE_OFF_BIT]; // [R16]
						soft_mute_fast_nxt = shift_r[audio_ctrl_pkg::SMUTE_FAST_BIT]; // [R16]
						loud_on_nxt        = !shift_r[audio_ctrl_pkg::LOUD_OFF_BIT]; // [R16]
						loud_20db_nxt      = shift_r[audio_ctrl_pkg::LOUD_20DB_BIT]; // [R16]
					end
					audio_ctrl_pkg::FUNC_INPUT: begin
						input_sel_nxt = shift_r[1:0]; // [R17]
					end
					audio_ctrl_pkg::FUNC_CHANNEL: begin
						chan_sel_nxt = shift_r[1:0]; // [R18]
					end
					default: begin
						// prefix 111 has no function; the byte was still acknowledged
						chan_sel_nxt = chan_sel_r; // [R20]
					end
				endcase
			end
		end
		// mute flag follows the new code so it lands in the same cycle as the volume
		left_mute_nxt  = (left_vol_nxt[6:5] == audio_ctrl_pkg::VOL_MUTE_CODE); // [R15]
		right_mute_nxt = (right_vol_nxt[6:5] == audio_ctrl_pkg::VOL_MUTE_CODE); // [R15]
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			left_vol_r       <= audio_ctrl_pkg::VOL_RESET;
			right_vol_r      <= audio_ctrl_pkg::VOL_RESET;
			left_mute_r      <= 1'h1;
			right_mute_r     <= 1'h1;
			soft_mute_on_r   <= audio_ctrl_pkg::SMUTE_ON_RESET;
			soft_mute_fast_r <= audio_ctrl_pkg::SMUTE_FAST_RST;
			loud_on_r        <= audio_ctrl_pkg::LOUD_ON_RESET;
			loud_20db_r      <= audio_ctrl_pkg::LOUD_20_RESET;
			input_sel_r      <= audio_ctrl_pkg::INPUT_RESET;
			chan_sel_r       <= audio_ctrl_pkg::CHAN_RESET;
		end else begin
			left_vol_r       <= left_vol_nxt;
			right_vol_r      <= right_vol_nxt;
			left_mute_r      <= left_mute_nxt;
			right_mute_r     <= right_mute_nxt;
			soft_mute_on_r   <= soft_mute_on_nxt;
			soft_mute_fast_r <= soft_mute_fast_nxt;
			loud_on_r        <= loud_on_nxt;
			loud_20db_r      <= loud_20db_nxt;
			input_sel_r      <= input_sel_nxt;
			chan_sel_r       <= chan_sel_nxt;
		end
	end
endmodule : audio_ctrl_i2c_slave_rx
`default_nettype wire

// >>> sim/audio_ctrl_props.sv
// assertion checker for the two-wire slave receiver
`timescale 1ns/1ps
`default_nettype none
module audio_ctrl_props (
	// clock, reset and bus pins
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       scl,
	input wire logic       sda_i,
	input wire logic       sda_o_r,
	input wire logic       sda_oe_r,
	// settings and status
	input wire logic [6:0] left_vol_r,
	input wire logic       left_mute_r,
	input wire logic [6:0] right_vol_r,
	input wire logic       right_mute_r,
	input wire logic       loud_on_r,
	input wire logic [1:0] input_sel_r,
	input wire logic [1:0] chan_sel_r,
	input wire logic       addressed_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// open drain: a driven high would fight the pull-up
	drive_low_a: assert property (sda_o_r == 1'h0)
		else $error("data driven high");
	ack_in_low_a: assert property ($rose(sda_oe_r) |-> !scl)
		else $error("ack began while clock high");
	ack_hold_a: assert property ($rose(scl) && sda_oe_r |-> sda_oe_r [*8])
		else $error("ack dropped while clock high");
	ack_release_a: assert property ($fell(scl) && sda_oe_r |-> ##[4:8] !sda_oe_r)
		else $error("ack held past ninth pulse");
	mute_code_a: assert property (left_mute_r == (left_vol_r[6:5] == 2'h3)
		&& right_mute_r == (right_vol_r[6:5] == 2'h3))
		else $error("mute does not follow volume code");
	// settings may only move at the data acknowledge
	func_sel_a: assert property (!$rose(sda_oe_r)
		|-> $stable({input_sel_r, chan_sel_r, loud_on_r}))
		else $error("setting changed outside ack");
	idle_hold_a: assert property (!addressed_r |=> $stable({left_vol_r, right_vol_r}))
		else $error("volume changed while not addressed");
	// pin to filtered level takes four clocks, so the clear shows about five clocks later
	stop_clear_a: assert property (scl && $past(scl) && $rose(sda_i)
		|-> ##[4:7] !addressed_r)
		else $error("stop not seen");
	start_clear_a: assert property (scl && $past(scl) && $fell(sda_i)
		|-> ##[4:7] !addressed_r)
		else $error("start not seen");
endmodule : audio_ctrl_props
bind audio_ctrl_i2c_slave_rx audio_ctrl_props audio_ctrl_props_i (.mclk, .rst_n, .scl, .sda_i,
	.sda_o_r, .sda_oe_r, .left_vol_r, .left_mute_r, .right_vol_r, .right_mute_r, .loud_on_r,
	.input_sel_r, .chan_sel_r, .addressed_r);
`default_nettype wire

// >>> sim/bus_master_model.sv
// behavioural bus master: drives the clock, pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
	// bench clock
	input wire logic mclk,
	// bus lines
	output var logic scl,
	output var logic pull_r,
	input wire logic sda
);
	// idle bus: both lines high
	initial begin
		scl = 1'h1;
		pull_r = 1'h0;
	end
	// quarter and half of the 160 ns bus clock
	task automatic q;
		repeat (8) @(posedge mclk);
	endtask : q
	// far faster than the 100 kbit/s bus ceiling to keep runs short; the receiver
	// only needs a few clocks per half period, so the protocol is exercised alike
	task automatic hp;
		repeat (16) @(posedge mclk);
	endtask : hp
	// also serves as repeated start from a low clock
	task automatic start;
		q;
		pull_r <= 1'h0;
		q;
		scl <= 1'h1;
		hp;
		pull_r <= 1'h1;
		hp;
		scl <= 1'h0;
	endtask : start
	task automatic stop;
		q;
		pull_r <= 1'h1;
		q;
		scl <= 1'h1;
		hp;
		pull_r <= 1'h0;
		hp;
	endtask : stop
	// data moves mid-low so it never changes under a high clock
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			q;
			pull_r <= !b[i];
			q;
			scl <= 1'h1;
			hp;
			scl <= 1'h0;
		end
		q;
		pull_r <= 1'h0;
		q;
		scl <= 1'h1;
		hp;
		ack = !sda;
		scl <= 1'h0;
	endtask : put_byte
endmodule : bus_master_model
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the two-wire slave receiver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// clock, reset, pins and outputs
	logic mclk = 1'h0;
	logic rst_n = 1'h0;
	logic addr_open = 1'h1;
	logic scl, pull_r, sda_o_r, sda_oe_r, addressed_r, ack;
	logic [6:0] left_vol_r, right_vol_r;
	logic left_mute_r, right_mute_r, soft_mute_on_r, soft_mute_fast_r, loud_on_r, loud_20db_r;
	logic [1:0] input_sel_r, chan_sel_r;
	wire logic sda = !(sda_oe_r | pull_r);
	// predicted settings, reset values first
	logic [6:0] el = 7'h7e;
	logic [6:0] er = 7'h7e;
	logic [1:0] ein = 2'h0;
	logic [1:0] ech = 2'h2;
	logic esm = 1'h0, esf = 1'h0, elo = 1'h0, el20 = 1'h0;
	logic [7:0] rnd = 8'h3d;
	logic [7:0] corner [16] = '{8'hc0, 8'h05, 8'hc1, 8'h6a, 8'hc2, 8'h13, 8'h80, 8'h9d,
		8'h91, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'he5, 8'hc3, 8'h58};
	int err_total = 0;
	int total_checks = 0;
	int j = 0;
	always #2.5 mclk = !mclk;
	audio_ctrl_i2c_slave_rx audio_ctrl_i2c_slave_rx_i (.mclk, .rst_n, .scl, .sda_i(sda), .sda_o_r,
		.sda_oe_r, .addr_open, .left_vol_r, .left_mute_r, .right_vol_r, .right_mute_r,
		.soft_mute_on_r, .soft_mute_fast_r, .loud_on_r, .loud_20db_r, .input_sel_r, .chan_sel_r,
		.addressed_r);
	bus_master_model bus_master_model_i (.mclk, .scl, .pull_r, .sda);
	// next random byte
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	// channel code 1x writes both sides; prefix 111 changes nothing
	function automatic void predict(input logic [7:0] b);
		if (!b[7]) begin
			if (ech != 2'h0) el = b[6:0];
			if (ech != 2'h1) er = b[6:0];
		end
		else if (b[6:5] == 2'h0) {elo, el20, esm, esf} = {!b[3], b[4], !b[2], b[0]};
		else if (b[6:5] == 2'h1) ein = b[1:0];
		else if (b[6:5] == 2'h2) ech = b[1:0];
	endfunction : predict
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic chk_set;
		chk({left_vol_r, left_mute_r}, {el, &el[6:5]});
		chk({right_vol_r, right_mute_r}, {er, &er[6:5]});
		chk({soft_mute_on_r, soft_mute_fast_r, loud_on_r, loud_20db_r}, {esm, esf, elo, el20});
		chk({input_sel_r, chan_sel_r}, {ein, ech});
	endtask : chk_set
	task automatic send(input logic [7:0] b);
		bus_master_model_i.put_byte(b, ack);
		predict(b);
		chk(ack, 1'h1);
		chk(addressed_r, 1'h1);
		chk_set;
	endtask : send
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	// watchdog sized well above the expected run of about 62k cycles
	initial begin
		repeat (95000) @(posedge mclk);
		err_total++;
		give_verdict;
	end
	// strap and address table, then corner and random traffic
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (8) @(posedge mclk);
		chk_set;
		chk(addressed_r, 1'h0);
		for (int k = 0; k < 8; k++) begin
			addr_open <= k[0];
			repeat (8) @(posedge mclk);
			bus_master_model_i.start;
			bus_master_model_i.put_byte({6'h0c, k[1], k[2]}, ack);
			chk(ack, !k[2] && k[1] == k[0]);
			if (ack) send(8'h47);
			else begin
				// no acknowledge, yet the master goes on without checking it
				bus_master_model_i.put_byte(8'h47, ack);
				chk(ack, 1'h0);
				chk(addressed_r, 1'h0);
				chk_set;
			end
			bus_master_model_i.stop;
			chk(addressed_r, 1'h0);
		end
		for (int t = 0; t < 60; t++) begin
			bus_master_model_i.start;
			bus_master_model_i.put_byte(addr_open ? 8'h32 : 8'h30, ack);
			chk(ack, 1'h1);
			for (int n = 0; n <= t % 3; n++) begin
				rnd = lfsr(rnd);
				send(j < 16 ? corner[j] : rnd);
				j++;
			end
			if (t % 4 != 3) bus_master_model_i.stop;
		end
		bus_master_model_i.stop;
		give_verdict;
	end
endmodule : tb_top
`default_nettype wire
